//--- logic/sxip_defines.vh
/*
 * constants for the serial flash execute-in-place unit: clock divide factors,
 * frame lengths, bit positions and engine state codes.
 * assumes inclusion by bare name from the design modules.
 */
`ifndef SXIP_DEFINES_VH
`define SXIP_DEFINES_VH

// ==========================================================================
// divider limits, one below each factor (2..4096), so 4096 still fits twelve bits
`define SXIP_LIM_0 12'h001
`define SXIP_LIM_1 12'h003
`define SXIP_LIM_2 12'h007
`define SXIP_LIM_3 12'h03f
`define SXIP_LIM_4 12'h07f
`define SXIP_LIM_5 12'h3ff
`define SXIP_LIM_6 12'h7ff
`define SXIP_LIM_7 12'hfff

// ==========================================================================
// frame geometry
`define SXIP_SHIFT_W 72
`define SXIP_RX_W 32
`define SXIP_CMD_W 8
`define SXIP_XIP_BASE_BITS 7'h30
`define SXIP_PAGE_HI 31
`define SXIP_PAGE_LO 28
`define SXIP_FLASH_ADDR_HI 27

// ==========================================================================
// engine states
`define SXIP_ST_IDLE 2'h0
`define SXIP_ST_SHIFT 2'h1
`define SXIP_ST_DONE 2'h2

`endif

//--- logic/sxip_buf.v
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock and a synchronous clear from the parent.
 */
`timescale 1ns/1ps

module sxip_buf #(
   parameter WIDTH = 32
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   input wire clr_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   // ========================================================================
   // storage
   reg [WIDTH-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready_o = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r <= 2'h0;
         mem_r[0] <= {WIDTH{1'b0}};
         mem_r[1] <= {WIDTH{1'b0}};
      end else if (clr_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 2'h1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end

endmodule // sxip_buf

//--- logic/sxip_core.v
/*
 * serial flash execute-in-place unit: transparent read port, direct serial
 * transfers, prescaled serial clock in all four modes.
 * assumes control bits come from registers on the same clock, and that the
 * flash answers on the data input pin.
 */
//
// Behaviour
// R01: writes on the transparent port get an error response
// R02: msb first shifting, all four clock modes from polarity and phase bits
// R03: prescaler codes 0..7 give factors 2,4,8,64,128,1024,2048,4096
// R04: normal serial clock is main clock over twice the factor
// R05: half clock mode ignores the prescaler and runs at half main clock
// R06: read command field is the first byte of each transparent read
// R07: direct mode sends up to 64 bits from high and low data
// R08: high data is write only, receive data returns in low data
// R09: writing high data starts a direct transfer, low data does not
// R10: busy flag stays high while a serial transfer runs
// R11: software sets byte count between one and eight
// R12: software puts transmit data at the top of high and low
// R13: chip select asserted per transaction and released at its end
// R14: chip select only goes low while the permit bit is set
// R15: direct transfers only when enabled and execute mode off
// R16: accesses with address 31:28 equal to page are claimed
// R17: flash address taken from low bus address bits, wrapping allowed
// R18: software keeps the page clear of other memories
// R19: clearing enable resets the unit and aborts transfers
// R20: read frame is command, address bytes, then 32 data bits
// R21: address length field holds address bytes minus one
// R22: enabled but not in execute mode, page accesses return error
// R23: transparent read stalls until done then acknowledges once
`timescale 1ns/1ps
`include "sxip_defines.vh"

module sxip_core (
   // clock and reset
   input wire CORE_CLK_I,
   input wire RST_N_I,
   // control bits
   input wire MODULE_EN_I,
   input wire [2:0] PRESCALER_SELECT_I,
   input wire CLOCK_POLARITY_BIT_I,
   input wire CLOCK_PHASE_BIT_I,
   input wire [3:0] TRANSFER_BYTE_COUNT_I,
   input wire XIP_MODE_I,
   input wire [1:0] ADDRESS_LENGTH_FIELD_I,
   input wire [7:0] READ_CMD_I,
   input wire [3:0] PAGE_I,
   input wire CHIP_SELECT_PERMIT_I,
   input wire HALF_CLOCK_MODE_BIT_I,
   // status bits
   output wire SERIAL_ENGINE_BUSY_O,
   output wire XIP_BUSY_O,
   // direct data registers
   input wire DATA_LOW_REG_WE_I,
   input wire [31:0] DATA_LOW_REG_WDATA_I,
   input wire DATA_HIGH_REG_WE_I,
   input wire [31:0] DATA_HIGH_REG_WDATA_I,
   output wire [31:0] DATA_LOW_REG_RDATA_O,
   // transparent flash port
   input wire XIP_REQ_I,
   input wire XIP_WE_I,
   input wire [31:0] XIP_ADDR_I,
   output wire XIP_ACK_O,
   output wire XIP_ERR_O,
   output wire [31:0] XIP_RDATA_O,
   input wire XIP_RSP_READY_I,
   // flash pins
   output wire SPI_CSN_O,
   output wire SPI_CLK_O,
   output wire SPI_SDO_O,
   input wire SPI_SDI_I
);

   // ========================================================================
   // reset release
   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n;

   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // ========================================================================
   // data input synchroniser
   reg sdi_s1_r;
   reg sdi_s2_r;

   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         sdi_s1_r <= 1'b0;
         sdi_s2_r <= 1'b0;
      end else begin
         sdi_s1_r <= SPI_SDI_I;
         sdi_s2_r <= sdi_s1_r;
      end
   end

   // ========================================================================
   // declarations
   reg [1:0] state_r;
   reg [`SXIP_SHIFT_W-1:0] tx_r;
   reg [`SXIP_RX_W-1:0] rx_r;
   reg [6:0] bits_r;
   reg half_r;
   reg first_r;
   reg sck_r;
   reg cs_r;
   reg is_xip_r;
   reg [11:0] div_cnt_r;
   reg [31:0] data_low_r;
   reg pend_r;
   reg [31:0] pend_addr_r;
   reg err_r;
   reg csn_o_r;
   reg sck_o_r;
   reg sdo_o_r;
   reg [11:0] div_lim;
   wire soft_clr;
   wire tick;
   wire claim;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [31:0] flash_addr;
   wire [31:0] addr_shifted;
   wire start_direct;
   wire start_xip;
   wire push_word;

   assign soft_clr = ~MODULE_EN_I; // [R19]

   // ========================================================================
   // serial clock divider
   always @* begin
      case (PRESCALER_SELECT_I) // [R03]
         3'h0: div_lim = `SXIP_LIM_0;
         3'h1: div_lim = `SXIP_LIM_1;
         3'h2: div_lim = `SXIP_LIM_2;
         3'h3: div_lim = `SXIP_LIM_3;
         3'h4: div_lim = `SXIP_LIM_4;
         3'h5: div_lim = `SXIP_LIM_5;
         3'h6: div_lim = `SXIP_LIM_6;
         default: div_lim = `SXIP_LIM_7;
      endcase
   end

   // one tick per half clock period: factor cycles normally, one cycle fast
   assign tick = (state_r != `SXIP_ST_IDLE) &
                 (HALF_CLOCK_MODE_BIT_I | (div_cnt_r == div_lim)); // [R04] [R05]

   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 12'h000;
      end else if (soft_clr || state_r == `SXIP_ST_IDLE || tick) begin
         div_cnt_r <= 12'h000;
      end else begin
         div_cnt_r <= div_cnt_r + 12'h001;
      end
   end

   // ========================================================================
   // transparent port decode
   assign claim = XIP_REQ_I & MODULE_EN_I &
                  (XIP_ADDR_I[`SXIP_PAGE_HI:`SXIP_PAGE_LO] == PAGE_I); // [R16]

   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
         pend_r <= 1'b0;
         pend_addr_r <= 32'h0000_0000;
      end else if (soft_clr) begin
         err_r <= 1'b0;
         pend_r <= 1'b0;
         pend_addr_r <= 32'h0000_0000;
      end else begin
         err_r <= claim & ~pend_r & (XIP_WE_I | ~XIP_MODE_I); // [R01] [R22]
         if (claim && !pend_r && !XIP_WE_I && XIP_MODE_I) begin
            pend_r <= 1'b1;
            pend_addr_r <= XIP_ADDR_I;
         end else if (start_xip) begin
            pend_r <= 1'b0;
         end
      end
   end

   // top four bits of a four-byte address are always zero
   assign flash_addr = {4'h0, pend_addr_r[`SXIP_FLASH_ADDR_HI:0]}; // [R17]
   assign addr_shifted = flash_addr << {~ADDRESS_LENGTH_FIELD_I, 3'h0}; // [R21]

   // ========================================================================
   // transfer starts
   assign start_xip = pend_r & (state_r == `SXIP_ST_IDLE) & buf_in_ready &
                      XIP_MODE_I & ~soft_clr;
   assign start_direct = DATA_HIGH_REG_WE_I & MODULE_EN_I & ~XIP_MODE_I &
                         (state_r == `SXIP_ST_IDLE); // [R09] [R15]
   // high data goes straight into the shifter: it is write only, so no copy is kept

   // ========================================================================
   // serial engine
   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= `SXIP_ST_IDLE;
         tx_r <= {`SXIP_SHIFT_W{1'b0}};
         rx_r <= 32'h0000_0000;
         bits_r <= 7'h00;
         half_r <= 1'b0;
         first_r <= 1'b0;
         sck_r <= 1'b0;
         cs_r <= 1'b0;
         is_xip_r <= 1'b0;
         data_low_r <= 32'h0000_0000;
      end else if (soft_clr) begin
         state_r <= `SXIP_ST_IDLE; // [R19]
         tx_r <= {`SXIP_SHIFT_W{1'b0}};
         rx_r <= 32'h0000_0000;
         bits_r <= 7'h00;
         first_r <= 1'b0;
         is_xip_r <= 1'b0;
         sck_r <= 1'b0;
         cs_r <= 1'b0;
         half_r <= 1'b0;
         data_low_r <= 32'h0000_0000;
      end else begin
         case (state_r)
            `SXIP_ST_IDLE: begin
               if (DATA_LOW_REG_WE_I && state_r == `SXIP_ST_IDLE) begin
                  data_low_r <= DATA_LOW_REG_WDATA_I;
               end
               if (start_xip) begin
                  tx_r <= {READ_CMD_I, addr_shifted, 32'h0000_0000}; // [R06] [R20]
                  bits_r <= `SXIP_XIP_BASE_BITS + {2'h0, ADDRESS_LENGTH_FIELD_I, 3'h0};
                  is_xip_r <= 1'b1;
                  cs_r <= 1'b1; // [R13]
                  half_r <= 1'b0;
                  first_r <= 1'b1;
                  sck_r <= 1'b0;
                  state_r <= `SXIP_ST_SHIFT;
               end else if (start_direct) begin
                  tx_r <= {DATA_HIGH_REG_WDATA_I, data_low_r, 8'h00}; // [R07]
                  bits_r <= {TRANSFER_BYTE_COUNT_I, 3'h0};
                  is_xip_r <= 1'b0;
                  cs_r <= 1'b1; // [R13]
                  half_r <= 1'b0;
                  first_r <= 1'b1;
                  sck_r <= 1'b0;
                  state_r <= `SXIP_ST_SHIFT;
               end
            end
            `SXIP_ST_SHIFT: begin
               if (tick) begin
                  half_r <= ~half_r;
                  if (!half_r) begin
                     sck_r <= 1'b1;
                     first_r <= 1'b0;
                     if (!CLOCK_PHASE_BIT_I) begin
                        rx_r <= {rx_r[30:0], sdi_s2_r}; // [R02]
                     end else if (!first_r) begin
                        tx_r <= {tx_r[`SXIP_SHIFT_W-2:0], 1'b0}; // [R02]
                     end
                  end else begin
                     sck_r <= 1'b0;
                     if (!CLOCK_PHASE_BIT_I) begin
                        tx_r <= {tx_r[`SXIP_SHIFT_W-2:0], 1'b0};
                     end else begin
                        rx_r <= {rx_r[30:0], sdi_s2_r};
                     end
                     bits_r <= bits_r - 7'h01;
                     if (bits_r == 7'h01) begin
                        state_r <= `SXIP_ST_DONE;
                     end
                  end
               end
            end
            `SXIP_ST_DONE: begin
               // one half period of hold before chip select lets go
               if (tick) begin
                  cs_r <= 1'b0; // [R13]
                  state_r <= `SXIP_ST_IDLE;
                  if (!is_xip_r) begin
                     data_low_r <= rx_r; // [R08]
                  end
               end
            end
            default: begin
               state_r <= `SXIP_ST_IDLE;
            end
         endcase
      end
   end

   assign push_word = (state_r == `SXIP_ST_DONE) & tick & is_xip_r & ~soft_clr;

   // ========================================================================
   // pin registers
   always @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         csn_o_r <= 1'b1;
         sck_o_r <= 1'b0;
         sdo_o_r <= 1'b0;
      end else begin
         csn_o_r <= ~(cs_r & CHIP_SELECT_PERMIT_I & ~soft_clr); // [R14]
         sck_o_r <= sck_r ^ CLOCK_POLARITY_BIT_I; // [R02]
         sdo_o_r <= tx_r[`SXIP_SHIFT_W-1];
      end
   end

   // ========================================================================
   // read answer buffer: two entries, so a stalled receiver holds back the third read
   sxip_buf #(
      .WIDTH(`SXIP_RX_W)
   ) u_buf (
      .clk_i(CORE_CLK_I),
      .rst_n_i(rst_n),
      .clr_i(soft_clr),
      .in_valid_i(push_word),
      .in_ready_o(buf_in_ready),
      .in_data_i(rx_r),
      .out_valid_o(buf_out_valid),
      .out_ready_i(XIP_RSP_READY_I),
      .out_data_o(XIP_RDATA_O)
   );

   // ========================================================================
   // outputs
   assign XIP_ACK_O = buf_out_valid; // [R23]
   assign XIP_ERR_O = err_r;
   assign SERIAL_ENGINE_BUSY_O = (state_r != `SXIP_ST_IDLE); // [R10]
   assign XIP_BUSY_O = pend_r | (is_xip_r & (state_r != `SXIP_ST_IDLE)) | buf_out_valid;
   assign DATA_LOW_REG_RDATA_O = data_low_r;
   assign SPI_CSN_O = csn_o_r;
   assign SPI_CLK_O = sck_o_r;
   assign SPI_SDO_O = sdo_o_r;

endmodule // sxip_core

//--- test/sxip_flash_model.sv
/* serial flash stand-in: records the bits it is sent and answers a fixed
   72-bit pattern, msb first. assumes the block's four flash pins. */
`timescale 1ns/1ps
module sxip_flash_model #(
   parameter logic [71:0] PAT = 72'h0
) (
   input wire logic csn_i,
   input wire logic sck_i,
   input wire logic sdo_i,
   input wire logic cpol_i,
   input wire logic cpha_i,
   output logic sdi_o,
   output logic [71:0] rx_o,
   output logic [7:0] nbits_o,
   output logic [7:0] frames_o
);
   int idx = 0;
   initial begin
      sdi_o = 1'h0;
      rx_o = 72'h0;
      nbits_o = 8'h0;
      frames_o = 8'h0;
   end
   // ====================
   // framing: a released line shows the inverse of its last bit
   always @(csn_i) begin
      if (csn_i === 1'h0) begin
         idx = cpha_i ? -1 : 0;
         nbits_o = 8'h0;
         rx_o = 72'h0;
         frames_o = frames_o + 8'h1;
         sdi_o = cpha_i ? ~sdi_o : PAT[71];
      end else begin
         sdi_o = ~sdi_o;
      end
   end
   // ====================
   // sample on leading edge for phase 0, trailing for phase 1
   always @(sck_i) begin
      if (csn_i === 1'h0) begin
         if ((sck_i !== cpol_i) ^ cpha_i) begin
            rx_o = {rx_o[70:0], sdo_i};
            nbits_o = nbits_o + 8'h1;
         end else begin
            idx = idx + 1;
            sdi_o = (idx < 72) ? PAT[71 - idx] : ~sdi_o;
         end
      end
   end
endmodule // sxip_flash_model

//--- test/sxip_core_asserts.sv
/* port assertions for the execute-in-place unit.
   assumes a bind to sxip_core, one clock, active-low reset. */
`timescale 1ns/1ps
module sxip_core_asserts (
   input wire logic CORE_CLK_I, RST_N_I, MODULE_EN_I, CLOCK_POLARITY_BIT_I, XIP_MODE_I,
   input wire logic CHIP_SELECT_PERMIT_I, SERIAL_ENGINE_BUSY_O, XIP_BUSY_O, DATA_LOW_REG_WE_I,
   input wire logic DATA_HIGH_REG_WE_I, XIP_REQ_I, XIP_WE_I, XIP_ACK_O, XIP_ERR_O,
   input wire logic XIP_RSP_READY_I, SPI_CSN_O, SPI_CLK_O,
   input wire logic [3:0] PAGE_I,
   input wire logic [31:0] XIP_ADDR_I,
   input wire logic [31:0] XIP_RDATA_O
);
   // ====================
   // helpers: internal reset lifts two edges after release, so wait it out
   logic [2:0] live_r;
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) live_r <= 3'h0;
      else if (live_r != 3'h4) live_r <= live_r + 3'h1;
   end
   wire live = live_r == 3'h4;
   wire hit = live && XIP_REQ_I && MODULE_EN_I && XIP_ADDR_I[31:28] == PAGE_I && !XIP_BUSY_O;
   wire eidle = live && !SERIAL_ENGINE_BUSY_O && !XIP_BUSY_O && !XIP_REQ_I;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // ====================
   // properties
   wr_err_a: assert property (hit && XIP_WE_I |=> XIP_ERR_O)
      else $error("write on read port not refused");
   mode_err_a: assert property (hit && !XIP_MODE_I |=> XIP_ERR_O)
      else $error("page access with mode off not refused");
   page_miss_a: assert property (XIP_REQ_I && XIP_ADDR_I[31:28] != PAGE_I |=> !XIP_ERR_O)
      else $error("foreign page answered");
   rd_take_a: assert property (hit && !XIP_WE_I && XIP_MODE_I |=> XIP_BUSY_O && !XIP_ERR_O)
      else $error("read not taken");
   cs_gate_a: assert property (!CHIP_SELECT_PERMIT_I [*3] |-> SPI_CSN_O)
      else $error("select low without permit");
   clk_idle_a: assert property (live && MODULE_EN_I && $past(MODULE_EN_I, 2) && SPI_CSN_O
      && !SERIAL_ENGINE_BUSY_O && $past(!SERIAL_ENGINE_BUSY_O) && $stable(CLOCK_POLARITY_BIT_I)
      && $past(CLOCK_POLARITY_BIT_I, 2) == CLOCK_POLARITY_BIT_I
      |-> SPI_CLK_O == CLOCK_POLARITY_BIT_I)
      else $error("idle clock level wrong");
   cs_busy_a: assert property (live && !SPI_CSN_O |-> SERIAL_ENGINE_BUSY_O
      || $past(SERIAL_ENGINE_BUSY_O)) else $error("select low while idle");
   hi_start_a: assert property (eidle && DATA_HIGH_REG_WE_I && MODULE_EN_I && !XIP_MODE_I
      |=> SERIAL_ENGINE_BUSY_O) else $error("high write did not start");
   lo_only_a: assert property (eidle && DATA_LOW_REG_WE_I && !DATA_HIGH_REG_WE_I
      |=> !SERIAL_ENGINE_BUSY_O) else $error("low write started a transfer");
   xip_block_a: assert property (eidle && DATA_HIGH_REG_WE_I && XIP_MODE_I
      |=> !SERIAL_ENGINE_BUSY_O) else $error("direct transfer in execute mode");
   abort_a: assert property (live && !MODULE_EN_I |=> !SERIAL_ENGINE_BUSY_O ##1 SPI_CSN_O)
      else $error("disable did not abort");
   ack_hold_a: assert property (XIP_ACK_O && !XIP_RSP_READY_I && MODULE_EN_I
      |=> XIP_ACK_O && $stable(XIP_RDATA_O)) else $error("answer not held");
   ack_once_a: assert property (XIP_ACK_O && XIP_RSP_READY_I |=> !XIP_ACK_O)
      else $error("answer repeated");
endmodule // sxip_core_asserts

//--- test/sxip_core_tb_top.sv
/* self-checking bench for sxip_core with a flash model on its pins.
   assumes the design under logic/ and the model and checker beside this. */
`timescale 1ns/1ps
module sxip_core_tb_top;
   typedef struct packed {logic [5:0] cfg; logic [12:0] per;} sxip_row_t;
   localparam logic [71:0] PAT = 72'h96_5a_c3_e1_0f_3c_a5_69_d2;
   logic CORE_CLK_I = 1'h0, RST_N_I = 1'h0, MODULE_EN_I = 1'h0, CLOCK_POLARITY_BIT_I = 1'h0;
   logic CLOCK_PHASE_BIT_I = 1'h0, XIP_MODE_I = 1'h0, CHIP_SELECT_PERMIT_I = 1'h1;
   logic HALF_CLOCK_MODE_BIT_I = 1'h0, DATA_LOW_REG_WE_I = 1'h0, DATA_HIGH_REG_WE_I = 1'h0;
   logic XIP_REQ_I = 1'h0, XIP_WE_I = 1'h0, XIP_RSP_READY_I = 1'h0;
   logic [2:0] PRESCALER_SELECT_I = 3'h2;
   logic [3:0] TRANSFER_BYTE_COUNT_I = 4'h8, PAGE_I = 4'h2; // page clear of other memories
   logic [1:0] ADDRESS_LENGTH_FIELD_I = 2'h2;
   logic [7:0] READ_CMD_I = 8'h03, nbits, frames;
   logic [31:0] DATA_LOW_REG_WDATA_I = 32'h0, DATA_HIGH_REG_WDATA_I = 32'h0, XIP_ADDR_I = 32'h0;
   logic SERIAL_ENGINE_BUSY_O, XIP_BUSY_O, XIP_ACK_O, XIP_ERR_O, SPI_CSN_O, SPI_CLK_O;
   logic SPI_SDO_O, SPI_SDI_I;
   logic [31:0] DATA_LOW_REG_RDATA_O, XIP_RDATA_O;
   logic [71:0] rx;
   int num_errors = 0, cmp_count = 0;
   // mode {prescaler, half, polarity, phase} beside the expected half period
   sxip_row_t rows [9] = '{'{6'h00, 13'h2}, '{6'h0a, 13'h4}, '{6'h11, 13'h8},
      '{6'h1b, 13'h40}, '{6'h20, 13'h80}, '{6'h2a, 13'h400}, '{6'h31, 13'h800},
      '{6'h3b, 13'h1000}, '{6'h3c, 13'h1}};
   sxip_core dut_u (.*);
   sxip_flash_model #(.PAT(PAT)) flash_u (.csn_i(SPI_CSN_O), .sck_i(SPI_CLK_O),
      .sdo_i(SPI_SDO_O), .cpol_i(CLOCK_POLARITY_BIT_I), .cpha_i(CLOCK_PHASE_BIT_I),
      .sdi_o(SPI_SDI_I), .rx_o(rx), .nbits_o(nbits), .frames_o(frames));
   always #5 CORE_CLK_I = ~CORE_CLK_I;
   // ====================
   // tasks
   task automatic chk(input string what, input logic [71:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge CORE_CLK_I);
      #1;
   endtask
   task automatic bail;
      num_errors++;
      conclude();
   endtask
   task automatic dw(input logic lw, hw, input logic [31:0] v);
      DATA_LOW_REG_WE_I = lw;
      DATA_HIGH_REG_WE_I = hw;
      DATA_LOW_REG_WDATA_I = v;
      DATA_HIGH_REG_WDATA_I = v;
      tick();
   endtask
   task automatic toggle(output int t);
      logic lvl;
      lvl = SPI_CLK_O;
      for (t = 1; t < 9000; t++) begin
         tick();
         if (SPI_CLK_O !== lvl) break;
      end
      if (t == 9000) bail();
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 20000 && {SERIAL_ENGINE_BUSY_O, XIP_BUSY_O} !== 2'h0; i++) tick();
      if (i == 20000) bail();
   endtask
   task automatic xreq(input logic we, input logic [31:0] a, output int errs);
      XIP_REQ_I = 1'h1;
      XIP_WE_I = we;
      XIP_ADDR_I = a;
      tick();
      XIP_REQ_I = 1'h0;
      errs = 0;
      repeat (3) begin
         errs += (XIP_ERR_O === 1'h1);
         tick();
      end
   endtask
   task automatic xread(input logic [31:0] a, input logic [1:0] ab);
      int e, i, n;
      logic [71:0] x;
      ADDRESS_LENGTH_FIELD_I = ab;
      READ_CMD_I = ab[0] ? 8'h0b : 8'h03;
      n = 8 * ab + 8;
      x = ((72'(READ_CMD_I) << n) | (72'(a[27:0]) & ~({72{1'h1}} << n))) << 32;
      xreq(1'h0, a, e);
      for (i = 0; i < 5000 && XIP_ACK_O !== 1'h1; i++) tick();
      if (i == 5000) bail();
      tick(4);
      chk("read errors", e, 0);
      chk("read bits", nbits, n + 40);
      chk("read stream", rx, x);
      chk("read word", XIP_RDATA_O, PAT[63 - n -: 32]);
      XIP_RSP_READY_I = 1'h1;
      tick();
      XIP_RSP_READY_I = 1'h0;
      tick();
      chk("ack dropped", XIP_ACK_O, 1'h0);
   endtask
   // ====================
   // main sequence
   initial begin
      int t, f, e;
      tick(6);
      RST_N_I = 1'h1;
      tick(4);
      chk("reset select", SPI_CSN_O, 1'h1);
      chk("reset busy", {SERIAL_ENGINE_BUSY_O, XIP_ACK_O}, 2'h0);
      chk("reset low data", DATA_LOW_REG_RDATA_O, 32'h0);
      MODULE_EN_I = 1'h1;
      foreach (rows[i]) begin
         {PRESCALER_SELECT_I, HALF_CLOCK_MODE_BIT_I, CLOCK_POLARITY_BIT_I, CLOCK_PHASE_BIT_I} =
            rows[i].cfg;
         tick(3);
         dw(1'h0, 1'h1, 32'h0);
         dw(1'h0, 1'h0, 32'h0);
         toggle(t);
         toggle(t);
         chk("half period", t, rows[i].per);
         MODULE_EN_I = 1'h0;
         tick();
         chk("abort busy", SERIAL_ENGINE_BUSY_O, 1'h0);
         MODULE_EN_I = 1'h1;
         tick(2);
         chk("abort select", SPI_CSN_O, 1'h1);
      end
      {PRESCALER_SELECT_I, HALF_CLOCK_MODE_BIT_I, CLOCK_POLARITY_BIT_I, CLOCK_PHASE_BIT_I} = 6'h10;
      tick(3);
      f = frames;
      dw(1'h1, 1'h0, 32'h8765_4321);
      dw(1'h0, 1'h1, 32'hc0de_1234);
      chk("busy", SERIAL_ENGINE_BUSY_O, 1'h1);
      dw(1'h0, 1'h0, 32'h0);
      tick(20);
      // writes while busy must be dropped
      dw(1'h1, 1'h1, 32'hffff_ffff);
      dw(1'h0, 1'h0, 32'h0);
      wait_idle();
      chk("frames", frames, f + 1);
      chk("stream", rx, {8'h0, 32'hc0de_1234, 32'h8765_4321});
      chk("receive", DATA_LOW_REG_RDATA_O, PAT[39:8]);
      {CLOCK_POLARITY_BIT_I, CLOCK_PHASE_BIT_I} = 2'h3;
      TRANSFER_BYTE_COUNT_I = 4'h4;
      tick(3);
      dw(1'h0, 1'h1, 32'ha1b2_c3d4);
      dw(1'h0, 1'h0, 32'h0);
      wait_idle();
      chk("mode 3 stream", rx, 72'ha1b2_c3d4);
      chk("mode 3 receive", DATA_LOW_REG_RDATA_O, PAT[71:40]);
      CHIP_SELECT_PERMIT_I = 1'h0;
      f = frames;
      dw(1'h0, 1'h1, 32'h5555_5555);
      dw(1'h0, 1'h0, 32'h0);
      wait_idle();
      chk("gated frames", frames, f);
      {CHIP_SELECT_PERMIT_I, CLOCK_POLARITY_BIT_I, CLOCK_PHASE_BIT_I} = 3'h4;
      // reads run at factor 8 to keep the run short; still slack for the input lag
      PRESCALER_SELECT_I = 3'h2;
      TRANSFER_BYTE_COUNT_I = 4'h8;
      tick(3);
      xreq(1'h0, 32'h2000_0000, e);
      chk("mode off error", e, 1);
      XIP_MODE_I = 1'h1;
      dw(1'h0, 1'h1, 32'h1234_5678);
      chk("blocked direct", SERIAL_ENGINE_BUSY_O, 1'h0);
      dw(1'h0, 1'h0, 32'h0);
      xreq(1'h1, 32'h2000_0010, e);
      chk("write error", e, 1);
      xreq(1'h0, 32'h3000_0000, e);
      chk("foreign page", {e, XIP_BUSY_O}, 0);
      MODULE_EN_I = 1'h0;
      xreq(1'h0, 32'h2000_0000, e);
      MODULE_EN_I = 1'h1;
      chk("disabled page", {e, XIP_BUSY_O}, 0);
      for (int ab = 0; ab < 4; ab++) xread(32'h2abc_def0 + ab, 2'(ab));
      // mid-run reset: pins fall back to idle at once, mid-frame included
      XIP_MODE_I = 1'h0;
      dw(1'h0, 1'h1, 32'h0f0f_0f0f);
      dw(1'h0, 1'h0, 32'h0);
      tick(40);
      chk("frame running", SPI_CSN_O, 1'h0);
      RST_N_I = 1'h0;
      #1;
      chk("async reset", {SPI_CSN_O, SERIAL_ENGINE_BUSY_O}, 2'h2);
      tick(2);
      RST_N_I = 1'h1;
      tick(3);
      chk("released busy", {SERIAL_ENGINE_BUSY_O, XIP_BUSY_O}, 2'h0);
      chk("released low data", DATA_LOW_REG_RDATA_O, 32'h0);
      conclude();
   end
endmodule // sxip_core_tb_top

bind sxip_core sxip_core_asserts chk_u (.*);
